//--- hdl/ebt_bus_cycle.sv
`default_nettype none
module ebt_bus_cycle
	import ebt_pkg::*;
(
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	// cpu request side
	input wire logic reqValid,
	input wire ebt_req_t req,
	output logic reqReady,
	output logic done,
	output logic [15:0] rdata,
	input wire logic nextExtFetch,
	output logic cpuStall,
	// configuration
	input wire logic [15:0] bus_window_config,
	input wire logic select_timing_cfg,
	// external bus pins
	output logic ale,
	output logic rdN,
	output logic wrN,
	output logic [CS_LINES-1:0] csN,
	output logic [23:0] addrOut,
	output logic addrEnN,
	output logic [15:0] dataOut,
	output logic dataEnN,
	input wire logic [15:0] dataIn,
	input wire logic readyPin
);
	ebt_state_t state;
	ebt_win_cfg_t cfg;
	ebt_req_t cur;
	logic csEarly;
	logic cntLoad;
	logic [5:0] cntVal;
	logic cntExpired;
	logic readyPinSync;
	logic readyAsync;
	logic readySeen;
	logic [15:0] dataSync;
	logic cmdDone;
	logic [CS_LINES-1:0] csTarget;

	function automatic ebt_win_cfg_t decode_cfg(input logic [15:0] w);
		ebt_win_cfg_t c;
		c.waitCount = w[WAIT_MSB:WAIT_LSB];
		c.asyncReady = w[ASYNC_BIT];
		c.cmdDelayBit = w[CMD_DELAY_BIT];
		c.tristateBit = w[TRISTATE_BIT];
		c.multiplexed = w[MUX_BIT];
		c.readyEnable = w[READY_EN_BIT];
		c.readyLevel = w[READY_LEVEL_BIT];
		return c;
	endfunction : decode_cfg

	// command phase length in system cycles, less the delay half
	function automatic logic [5:0] cmd_len(input ebt_win_cfg_t c);
		logic [5:0] waits;
		logic [5:0] len;
		waits = '0;
		len = '0;
		if (c.readyEnable) begin
			waits = {3'h0, c.waitCount[2:0]};
		end else begin
			waits = {2'h0, WAIT_MAX - c.waitCount};
		end
		len = 6'(CPU_CYC + 6'(waits * CPU_CYC));
		// async ready sampled one half earlier
		if (c.readyEnable && c.asyncReady) begin
			len = len - HALF_CYC;
		end
		// delayed strobe ends on the same edge as undelayed
		if (!c.cmdDelayBit) begin
			len = len - HALF_CYC;
		end
		return len;
	endfunction : cmd_len

	function automatic logic [5:0] tri_len(input ebt_win_cfg_t c);
		logic [5:0] len;
		len = '0;
		if (!c.tristateBit) begin
			len = len + CPU_CYC;
		end
		if (c.multiplexed) begin
			len = len + CPU_CYC;
		end
		return len;
	endfunction : tri_len

	function automatic logic [CS_LINES-1:0] cs_decode(input logic [2:0] s);
		logic [CS_LINES-1:0] v;
		v = '1;
		if (32'(s) < CS_LINES) begin
			v[s] = 1'b0;
		end
		return v;
	endfunction : cs_decode

	// pin inputs pass two flops before any logic reads them
	ebt_sync #(
		.W(1)
	) u_ready_pin (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.din(readyPin),
		.dout(readyPinSync)
	);

	// extra stages cost the asynchronous mode its sync delay
	ebt_sync #(
		.W(1)
	) u_ready_async (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.din(readyPinSync),
		.dout(readyAsync)
	);

	ebt_sync #(
		.W(16)
	) u_data_in (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.din(dataIn),
		.dout(dataSync)
	);

	ebt_wait_cnt #(
		.W(6)
	) u_wait (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.load(cntLoad),
		.loadVal(cntVal),
		.expired(cntExpired)
	);

	assign csTarget = cs_decode(cur.csSel);

	always_comb begin
		if (cfg.asyncReady) begin
			readySeen = (readyAsync == cfg.readyLevel);
		end else begin
			readySeen = (readyPinSync == cfg.readyLevel);
		end
	end

	// no timeout: a ready window waits for ready forever
	assign cmdDone = (state == ST_CMD) && cntExpired &&
		(!cfg.readyEnable || readySeen);

	// counter reload on entry to command and tri-state phases
	always_comb begin
		cntLoad = 1'b0;
		cntVal = '0;
		if ((state == ST_ADDR && cfg.cmdDelayBit) || state == ST_DELAY) begin
			cntLoad = 1'b1;
			// a zero-length command still lasts one cycle
			cntVal = (cmd_len(cfg) == '0) ? '0 : cmd_len(cfg) - 6'h01;
		end else if (cmdDone) begin
			cntLoad = 1'b1;
			cntVal = tri_len(cfg) - 6'h01;
		end
	end

	// sequencer
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			state <= ST_IDLE;
		end else begin
			case (state)
				ST_IDLE: begin
					if (reqValid) begin
						state <= ST_ADDR;
					end
				end
				ST_ADDR: begin
					if (!cfg.cmdDelayBit) begin
						state <= ST_DELAY;
					end else begin
						state <= ST_CMD;
					end
				end
				ST_DELAY: begin
					state <= ST_CMD;
				end
				ST_CMD: begin
					if (cmdDone) begin
						if (tri_len(cfg) == '0) begin
							state <= ST_IDLE;
						end else begin
							state <= ST_TRI;
						end
					end
				end
				ST_TRI: begin
					if (cntExpired) begin
						state <= ST_IDLE;
					end
				end
				default: begin
					state <= ST_IDLE;
				end
			endcase
		end
	end

	// request and window settings held for the whole cycle
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			cur <= '0;
			cfg <= decode_cfg(WIN_CFG_RESET);
			csEarly <= SELECT_TIMING_RESET;
		end else if (state == ST_IDLE && reqValid) begin
			cur <= req;
			cfg <= decode_cfg(bus_window_config);
			csEarly <= select_timing_cfg;
		end
	end

	// latch strobe and address
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			ale <= 1'b0;
			addrOut <= '0;
			addrEnN <= 1'b1;
		end else begin
			ale <= (state == ST_IDLE) && reqValid;
			if (state == ST_IDLE && reqValid) begin
				addrOut <= req.addr;
				addrEnN <= 1'b0;
			end else if (cmdDone) begin
				addrEnN <= 1'b1;
			end
		end
	end

	// chip selects
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			csN <= '1;
		end else if (state == ST_IDLE && reqValid && select_timing_cfg) begin
			csN <= cs_decode(req.csSel);
		end else if (state == ST_ADDR && !csEarly) begin
			csN <= csTarget;
		end
	end

	// command strobes; undelayed strobe falls as the latch strobe falls
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			rdN <= 1'b1;
			wrN <= 1'b1;
		end else if ((state == ST_ADDR && cfg.cmdDelayBit) ||
			state == ST_DELAY) begin
			rdN <= cur.write;
			wrN <= !cur.write;
		end else if (cmdDone) begin
			rdN <= 1'b1;
			wrN <= 1'b1;
		end
	end

	// write data driven for the command; read data taken at its end
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			dataOut <= '0;
			dataEnN <= 1'b1;
			rdata <= '0;
			done <= 1'b0;
		end else begin
			done <= cmdDone;
			if (state == ST_ADDR && cur.write) begin
				dataOut <= cur.wdata;
				dataEnN <= 1'b0;
			end else if (cmdDone) begin
				dataEnN <= 1'b1;
			end
			if (cmdDone && !cur.write) begin
				rdata <= dataSync;
			end
		end
	end

	// next address only once the tri-state interval is over
	assign reqReady = (state == ST_IDLE);
	// cpu keeps running unless it needs the bus again
	assign cpuStall = (state != ST_IDLE) && nextExtFetch;
endmodule : ebt_bus_cycle
`default_nettype wire

//--- hdl/ebt_pkg.sv
`default_nettype none
package ebt_pkg;
	// clock figures; one cpu clock spans two system cycles (one per half)
	localparam int CLK_PERIOD_NS = 20;
	localparam int CPU_CLK_PERIOD_NS = 40;
	localparam int HALF_PER_CPU = CPU_CLK_PERIOD_NS / CLK_PERIOD_NS;
	localparam logic [5:0] CPU_CYC = 6'(HALF_PER_CPU);
	localparam logic [5:0] HALF_CYC = 6'(HALF_PER_CPU / 2);
	// memory cycle wait-states
	localparam logic [3:0] WAIT_MAX = 4'hf;
	// window configuration word field positions
	localparam int WAIT_LSB = 0;
	localparam int WAIT_MSB = 3;
	localparam int ASYNC_BIT = 3;
	localparam int CMD_DELAY_BIT = 4;
	localparam int TRISTATE_BIT = 5;
	localparam int MUX_BIT = 6;
	localparam int READY_EN_BIT = 12;
	localparam int READY_LEVEL_BIT = 13;
	// reset values of the window controls
	localparam logic [15:0] WIN_CFG_RESET = 16'h0000;
	localparam logic SELECT_TIMING_RESET = 1'b0;
	localparam int CS_LINES = 5;
	localparam int SYNC_STAGES = 2;

	typedef struct packed {
		logic [3:0] waitCount;
		logic asyncReady;
		logic cmdDelayBit;
		logic tristateBit;
		logic multiplexed;
		logic readyEnable;
		logic readyLevel;
	} ebt_win_cfg_t;

	typedef struct packed {
		logic write;
		logic [2:0] csSel;
		logic [23:0] addr;
		logic [15:0] wdata;
	} ebt_req_t;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_ADDR,
		ST_DELAY,
		ST_CMD,
		ST_TRI
	} ebt_state_t;
endpackage : ebt_pkg
`default_nettype wire

//--- hdl/ebt_sync.sv
`default_nettype none
module ebt_sync
	import ebt_pkg::*;
#(
	parameter int W = 1
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	// level in and out
	input wire logic [W-1:0] din,
	output logic [W-1:0] dout
);
	logic [W-1:0] stage1;

	// first stage feeds only the second
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			stage1 <= '0;
			dout <= '0;
		end else begin
			stage1 <= din;
			dout <= stage1;
		end
	end
endmodule : ebt_sync
`default_nettype wire

//--- hdl/ebt_wait_cnt.sv
`default_nettype none
module ebt_wait_cnt
	import ebt_pkg::*;
#(
	parameter int W = 6
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	// control
	input wire logic load,
	input wire logic [W-1:0] loadVal,
	// status
	output logic expired
);
	logic [W-1:0] count;

	// down counter; holds at zero until reloaded
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			count <= '0;
		end else if (load) begin
			count <= loadVal;
		end else if (count != '0) begin
			count <= count - W'(1);
		end
	end

	assign expired = (count == '0);
endmodule : ebt_wait_cnt
`default_nettype wire

//--- tb/ebt_mem_model.sv
`default_nettype none
module ebt_mem_model
	import ebt_pkg::*;
(
	// clock
	input wire logic clk_sys,
	// bus pins
	input wire logic rdN,
	input wire logic wrN,
	input wire logic [23:0] addrOut,
	// behaviour
	input wire logic level,
	input wire logic [7:0] lat,
	output logic [15:0] dataIn,
	output logic readyPin
);
	logic [7:0] cnt = 8'h00;
	logic [15:0] junk = 16'h5a5a;
	wire logic cmdLow = !(rdN && wrN);
	always_ff @(posedge clk_sys) begin
		// released bus toggles, no stale value
		junk <= ~junk;
		cnt <= cmdLow ? cnt + 8'h01 : 8'h00;
	end
	assign dataIn = rdN ? junk : ~addrOut[15:0];
	// lat zero: normally-ready part
	assign readyPin = (lat == 8'h00 || (cmdLow && cnt >= lat)) ? level
		: !level;
endmodule : ebt_mem_model
`default_nettype wire

//--- tb/ebt_bus_cycle_checker.sv
`default_nettype none
module ebt_bus_cycle_checker
	import ebt_pkg::*;
(
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	// cpu side
	input wire logic reqValid,
	input wire ebt_req_t req,
	input wire logic reqReady,
	input wire logic done,
	input wire logic nextExtFetch,
	input wire logic cpuStall,
	// config and pins
	input wire logic [15:0] bus_window_config,
	input wire logic select_timing_cfg,
	input wire logic ale,
	input wire logic rdN,
	input wire logic wrN,
	input wire logic [CS_LINES-1:0] csN
);
	logic [7:0] cnt;
	wire logic [15:0] cfg = bus_window_config;
	wire logic [7:0] expOff = 8'(32 - 2 * cfg[3:0]);
	wire logic [7:0] expOn = 8'(2 + 2 * cfg[2:0] - cfg[3]);
	wire logic [1:0] triN = 2'(!cfg[5]) + 2'(cfg[6]);
	wire logic [CS_LINES-1:0] tgt = ~(5'h01 << req.csSel);
	wire logic cmd = !(rdN && wrN);
	// cycles since latch strobe
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n)
			cnt <= 8'h00;
		else if (ale)
			cnt <= 8'h00;
		else
			cnt <= cnt + 8'h01;
	end
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	property p_take; ale |-> $past(reqValid && reqReady, 1); endproperty
	a_take: assert property (p_take) else $error("latch no request");
	property p_fast; $fell(ale) && cfg[4] |-> cmd; endproperty
	a_fast: assert property (p_fast) else $error("command late");
	property p_slow; $fell(ale) && !cfg[4] |-> !cmd ##1 cmd; endproperty
	a_slow: assert property (p_slow) else $error("no delay");
	property p_csEarly;
		$rose(ale) && select_timing_cfg && req.csSel < 3'h5 |-> csN == tgt;
	endproperty
	a_csEarly: assert property (p_csEarly) else $error("cs late");
	property p_csLate;
		$rose(ale) && !select_timing_cfg && req.csSel < 3'h5
		|-> csN != tgt ##1 csN == tgt;
	endproperty
	a_csLate: assert property (p_csLate) else $error("cs timing");
	property p_waitOff; done && !cfg[12] |-> cnt == expOff; endproperty
	a_waitOff: assert property (p_waitOff) else $error("waits");
	property p_waitOn; done && cfg[12] |-> cnt >= expOn; endproperty
	a_waitOn: assert property (p_waitOn) else $error("ready");
	property p_tri0; done && triN == 2'h0 |-> reqReady; endproperty
	a_tri0: assert property (p_tri0) else $error("tri zero");
	property p_tri1; done && triN == 2'h1 |-> !reqReady [*2] ##1 reqReady;
	endproperty
	a_tri1: assert property (p_tri1) else $error("tri one");
	property p_tri2;
		done && triN == 2'h2 |-> !reqReady [*4] ##1 reqReady;
	endproperty
	a_tri2: assert property (p_tri2) else $error("tri mux");
	property p_stall; cpuStall == (nextExtFetch && !reqReady); endproperty
	a_stall: assert property (p_stall) else $error("stall");
	c_mux: cover property (done && cfg[6]);
	c_ready: cover property (done && cfg[12]);
	c_stall: cover property (cpuStall);
endmodule : ebt_bus_cycle_checker
bind ebt_bus_cycle ebt_bus_cycle_checker ebt_bus_cycle_checker_i (.clk_sys,
	.rst_n, .reqValid, .req, .reqReady, .done, .nextExtFetch, .cpuStall,
	.bus_window_config, .select_timing_cfg, .ale, .rdN, .wrN, .csN);
`default_nettype wire

//--- tb/ebt_bus_cycle_tb_top.sv
`default_nettype none
module ebt_bus_cycle_tb_top
	import ebt_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk_sys = 0, rst_n = 0, reqValid = 0, nextExtFetch = 0;
	logic select_timing_cfg = 0, readyLevel = 0;
	logic reqReady, done, cpuStall, ale, rdN, wrN, addrEnN, dataEnN, readyPin;
	logic [15:0] bus_window_config = 16'h0000, rdata, dataOut, dataIn;
	logic [CS_LINES-1:0] csN;
	logic [23:0] addrOut;
	logic [7:0] lat = 8'h00;
	ebt_req_t req = '0;
	int num_errors = 0, comparisons = 0, n, m, L;
	logic [15:0] c;
	ebt_bus_cycle ebt_bus_cycle_i (.clk_sys, .rst_n, .reqValid, .req,
		.reqReady, .done, .rdata, .nextExtFetch, .cpuStall,
		.bus_window_config, .select_timing_cfg, .ale, .rdN, .wrN, .csN,
		.addrOut, .addrEnN, .dataOut, .dataEnN, .dataIn, .readyPin);
	ebt_mem_model ebt_mem_model_i (.clk_sys, .rdN, .wrN, .addrOut,
		.level(readyLevel), .lat, .dataIn, .readyPin);
	task check(input string name, input logic [15:0] seen, exp);
		comparisons++;
		if (seen !== exp) begin
			num_errors++;
			$display("mismatch %s exp %h seen %h", name, exp, seen);
		end
	endtask : check
	task summarize;
		if (num_errors == 0 && comparisons > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : summarize
	task to;
		num_errors++;
		summarize();
	endtask : to
	// expected undelayed command length in cycles
	function int lz(input logic [15:0] w);
		if (w[12])
			return 2 + 2 * w[2:0] - w[3];
		return 2 + 2 * (15 - w[3:0]);
	endfunction : lz
	// one bus cycle; counts edges to done and command-low cycles
	task cyc(input logic [15:0] w, input logic wr, input logic [2:0] cs,
		input logic sel);
		int k;
		k = 0;
		bus_window_config = w;
		select_timing_cfg = sel;
		req = '{wr, cs, {21'h0a5c3, cs}, 16'hc3a5};
		reqValid = 1;
		while (reqReady !== 1'b1) begin
			@(negedge clk_sys);
			if (++k > 300) to();
		end
		@(negedge clk_sys);
		reqValid = 0;
		n = 1;
		m = 0;
		while (done !== 1'b1) begin
			m += int'(rdN !== 1'b1 || wrN !== 1'b1);
			@(negedge clk_sys);
			if (++n > 300) to();
		end
		@(negedge clk_sys);
	endtask : cyc
	initial begin
		forever #10 clk_sys = ~clk_sys;
	end
	initial begin
		repeat (12) @(negedge clk_sys);
		rst_n = 1;
		for (int i = 0; i < 8; i++) begin
			c = {9'h000, i[2], i[1], i[0] & !i[2], 4'(15 - 2 * i)};
			nextExtFetch = i[1];
			cyc(c, i[0] ^ i[1], 3'(i), i[0] ^ i[2]);
			L = lz(c);
			check("cycle", 16'(n), 16'(L + 2));
			check("cmd", 16'(m), 16'(L - !c[4]));
			if (!(i[0] ^ i[1]) && L >= 6)
				check("rdata", rdata, ~req.addr[15:0]);
			check("addr", addrOut[15:0], req.addr[15:0]);
			check("release", {14'h0, addrEnN, dataEnN}, 16'h0003);
			if (i[0] ^ i[1])
				check("wdata", dataOut, req.wdata);
		end
		for (int j = 0; j < 4; j++) begin
			readyLevel = j[0];
			c = {2'h0, j[0], 1'b1, 8'h00, j[1], 3'h3};
			cyc(c, j[0], 3'(j), j[1]);
			check("ready", 16'(n), 16'(lz(c) + 2));
		end
		// late ready: cycle must wait for it
		readyLevel = 1;
		lat = 8'd60;
		cyc(16'h3008, 1'b0, 3'h4, 1'b0);
		check("hang", 16'(n > 60), 16'h0001);
		summarize();
	end
endmodule : ebt_bus_cycle_tb_top
`default_nettype wire
